// ==== verilog/timer_pkg.sv ====
/*
 * Shared constants, register map and carrier types of the 8/16-bit timer.
 * Assumes an 8-bit register port with byte addresses as printed below.
 */
package timer_pkg;

    // ==========================================================
    // register map
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam logic [11:0] ADDR_COUNT_LOW  = 12'hfd3;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'hfd4;
    localparam logic [11:0] ADDR_CTRL_A     = 12'hfd5;
    localparam logic [11:0] ADDR_CTRL_B     = 12'hfd6;
    localparam logic [11:0] ADDR_IRQ_CTRL   = 12'hfd7;

    // ==========================================================
    // reset values and field positions
    localparam logic [7:0]  CTRL_A_RESET    = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET    = 8'h00;
    localparam logic [7:0]  COUNT_RESET     = 8'h00;
    localparam logic [7:0]  READ_IDLE       = 8'h00;
    localparam logic        IRQ_RESET       = 1'b0;
    localparam int          IRQ_FLAG_BIT    = 0;
    localparam int          IRQ_ENABLE_BIT  = 1;
    localparam logic [15:0] COUNT16_MAX     = 16'hffff;

    // ==========================================================
    // clock sources
    localparam logic [2:0]  SRC_PIN         = 3'h0;
    localparam logic [2:0]  SRC_PIN_INV     = 3'h1;
    localparam logic [2:0]  SRC_INSTR       = 3'h2;
    localparam logic [2:0]  SRC_HFOSC       = 3'h3;
    localparam logic [2:0]  SRC_LFOSC       = 3'h4;
    localparam logic [2:0]  SRC_SECOSC      = 3'h5;
    localparam int          RAW_PIN         = 0;
    localparam int          RAW_HFOSC       = 1;
    localparam int          RAW_LFOSC       = 2;
    localparam int          RAW_SECOSC      = 3;
    localparam int          RAW_COUNT       = 4;

    // ==========================================================
    // timing and scaler widths
    localparam logic [1:0]  INSTR_DIV_LAST  = 2'h3;
    localparam int          PRES_W          = 15;
    localparam int          POST_W          = 4;

    typedef struct packed {
        logic       moduleEnable;
        logic       reserved;
        logic       outputStatusBit;
        logic       widthSelect;
        logic [3:0] postscaleField;
    } ctrl_a_t;

    typedef struct packed {
        logic [2:0] clockSourceField;
        logic       asyncEnable;
        logic [3:0] prescaleField;
    } ctrl_b_t;

    typedef struct packed {
        logic        wrStrobe;
        logic        rdStrobe;
        logic [11:0] addr;
        logic [7:0]  wrData;
    } bus_req_t;

endpackage

// ==== verilog/event_divider.sv ====
/*
 * Event divider: passes one input tick in every limit+1.
 * Assumes ticks are one-cycle pulses on clk_sys; clear restarts the count.
 */
module event_divider #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         clear,
    input  wire logic         inTick,
    input  wire logic [W-1:0] limit,
    output logic              outTick
);

    logic [W-1:0] count_q;

    // limit may shrink below the count; >= keeps it from running the full range
    assign outTick = inTick && (count_q >= limit);

    always_ff @(posedge clk_sys) begin
        if (srst || clear) begin
            count_q <= '0;
        end else if (outTick) begin
            count_q <= '0;
        end else if (inTick) begin
            count_q <= count_q + W'(1);
        end
    end

endmodule

// ==== verilog/clock_source_select.sv ====
/*
 * Clock source selection: synchronises the outside clock sources to clk_sys
 * and turns the chosen one into a one-cycle tick on its rising edge, or on the pin's falling edge for the inverted code.
 * Assumes every raw source is slower than half of clk_sys.
 */
module clock_source_select (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [3:0] rawSources,
    input  wire logic       instrTick,
    input  wire logic [2:0] clockSourceField,
    output logic            srcTick
);

    wire [3:0] riseSeen;
    wire [3:0] fallSeen;

    // ==========================================================
    // two-stage synchronisers, then an edge detector per source
    genvar gi;
    generate
        for (gi = 0; gi < timer_pkg::RAW_COUNT; gi++) begin : g_sync
            logic meta_q;
            logic level_q;
            logic prev_q;
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    meta_q  <= 1'b0;
                    level_q <= 1'b0;
                    prev_q  <= 1'b0;
                end else begin
                    meta_q  <= rawSources[gi];
                    level_q <= meta_q;
                    prev_q  <= level_q;
                end
            end
            assign riseSeen[gi] = level_q && !prev_q;
            assign fallSeen[gi] = !level_q && prev_q;
        end
    endgenerate

    // ==========================================================
    // source mux; reserved codes give no ticks
    always_comb begin
        case (clockSourceField)
            timer_pkg::SRC_PIN:     srcTick = riseSeen[timer_pkg::RAW_PIN];
            timer_pkg::SRC_PIN_INV: srcTick = fallSeen[timer_pkg::RAW_PIN];
            timer_pkg::SRC_INSTR:   srcTick = instrTick;
            timer_pkg::SRC_HFOSC:   srcTick = riseSeen[timer_pkg::RAW_HFOSC];
            timer_pkg::SRC_LFOSC:   srcTick = riseSeen[timer_pkg::RAW_LFOSC];
            timer_pkg::SRC_SECOSC:  srcTick = riseSeen[timer_pkg::RAW_SECOSC];
            default:                srcTick = 1'b0;
        endcase
    end

endmodule

// ==== verilog/timer_core.sv ====
/*
 * Top of the 8/16-bit timer: register port, counter, scalers, output and
 * interrupt flag. Assumes a single-cycle register master on clk_sys and a
 * sleep indication that is already synchronous to clk_sys.
 */
//
// Summary of operation
// - width select 1 gives a 16-bit counter, 0 an 8-bit period counter
// - counter advances once per prescaled tick of the chosen clock
// - 8-bit: low byte equal to period shadow clears and reloads shadow
// - 16-bit: reading low byte latches the live high byte into high register
// - 16-bit: high register write buffers; low byte write moves it into counter
// - 16-bit: counter wraps from all ones to zero and keeps running
// - three-bit field picks pin, inverted pin, instruction clock or oscillators
// - synchronous mode aligns counting to the instruction clock rate
// - asynchronous mode counts straight on each prescaler output tick
// - prescaler divides by two to the power of its field
// - prescaler is hidden and cleared by low byte, control writes, reset
// - postscaler divides match or wrap events by field plus one
// - postscaler is hidden and cleared by low byte, control writes, reset
// - output toggles whenever the postscaler completes its count
// - output shows in read-only bit five of control register a
// - output toggle sets interrupt flag; flag with enable requests interrupt
// - flag sets once per postscale field plus one events
// - synchronous mode stops counting during sleep
// - asynchronous mode keeps counting in sleep, except on the instruction clock, and raises wake when enabled
// - enable bit seven of control register a runs or stops the module
// - 16-bit mode has no hardware reload, only wrap and writes
// - 8-bit mode uses the high register as period, low restarts from zero
module timer_core (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire timer_pkg::bus_req_t busReq,
    output logic [7:0]               rdData,
    input  wire logic                pinIn,
    input  wire logic                hfOscIn,
    input  wire logic                lfOscIn,
    input  wire logic                secOscIn,
    input  wire logic                sleepActive,
    output logic                     timerOut,
    output logic                     irqRequest,
    output logic                     wakeRequest
);

    timer_pkg::ctrl_a_t ctrlA_q;
    timer_pkg::ctrl_b_t ctrlB_q;
    logic [7:0]         cntLow_q;
    logic [7:0]         cntHigh_q;
    logic [7:0]         hiReg_q;
    logic [7:0]         perShadow_q;
    logic [7:0]         rdData_q;
    logic [1:0]         instrDiv_q;
    logic               pend_q;
    logic               out_q;
    logic               irqFlag_q;
    logic               irqEnable_q;
    logic               wrLow;
    logic               wrHigh;
    logic               wrCtrlA;
    logic               wrCtrlB;
    logic               wrIrq;
    logic               rdLow;
    logic               scalerClear;
    logic               instrTick;
    logic               srcTick;
    logic               presTick;
    logic               countTick;
    logic               matchNow;
    logic               rollEvent;
    logic               postTick;
    logic [14:0]        presLimit;

    // ==========================================================
    // register decode
    assign wrLow   = busReq.wrStrobe && (busReq.addr == timer_pkg::ADDR_COUNT_LOW);
    assign wrHigh  = busReq.wrStrobe && (busReq.addr == timer_pkg::ADDR_COUNT_HIGH);
    assign wrCtrlA = busReq.wrStrobe && (busReq.addr == timer_pkg::ADDR_CTRL_A);
    assign wrCtrlB = busReq.wrStrobe && (busReq.addr == timer_pkg::ADDR_CTRL_B);
    assign wrIrq   = busReq.wrStrobe && (busReq.addr == timer_pkg::ADDR_IRQ_CTRL);
    assign rdLow   = busReq.rdStrobe && (busReq.addr == timer_pkg::ADDR_COUNT_LOW);

    assign scalerClear = wrLow || wrCtrlA || wrCtrlB;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlA_q <= timer_pkg::CTRL_A_RESET;
        end else if (wrCtrlA) begin
            ctrlA_q <= busReq.wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlB_q <= timer_pkg::CTRL_B_RESET;
        end else if (wrCtrlB) begin
            ctrlB_q <= busReq.wrData;
        end
    end

    // ==========================================================
    // instruction clock: one tick in four, absent during sleep
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            instrDiv_q <= 2'h0;
        end else begin
            instrDiv_q <= instrDiv_q + 2'h1;
        end
    end

    assign instrTick = (instrDiv_q == timer_pkg::INSTR_DIV_LAST) && !sleepActive;

    // ==========================================================
    // clock source and prescaler
    // source selection
    clock_source_select u_src (
        .clk_sys          (clk_sys),
        .srst             (srst),
        .rawSources       ({secOscIn, lfOscIn, hfOscIn, pinIn}),
        .instrTick        (instrTick),
        .clockSourceField (ctrlB_q.clockSourceField),
        .srcTick          (srcTick)
    );

    assign presLimit = 15'((16'h0001 << ctrlB_q.prescaleField) - 16'h0001);

    // disabled module feeds no ticks, so the prescaler holds
    event_divider #(
        .W (timer_pkg::PRES_W)
    ) u_pres (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clear   (scalerClear),
        .inTick  (srcTick && ctrlA_q.moduleEnable),
        .limit   (presLimit),
        .outTick (presTick)
    );

    // hold a prescaled tick until the next instruction tick
    // prescaled ticks seen while asleep are lost, not counted on waking
    always_ff @(posedge clk_sys) begin
        if (srst || scalerClear || !ctrlA_q.moduleEnable || sleepActive) begin
            pend_q <= 1'b0;
        end else if (presTick) begin
            pend_q <= 1'b1;
        end else if (instrTick) begin
            pend_q <= 1'b0;
        end
    end

    // asynchronous mode counts straight on the prescaler output
    assign countTick = ctrlA_q.moduleEnable &&
                       (ctrlB_q.asyncEnable ? presTick : (pend_q && instrTick));

    // ==========================================================
    // counter
    assign matchNow = (cntLow_q == perShadow_q);

    // one postscaler event per match or wrap
    assign rollEvent = countTick && !wrLow &&
                       (ctrlA_q.widthSelect ? ({cntHigh_q, cntLow_q} == timer_pkg::COUNT16_MAX) : matchNow);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cntLow_q    <= timer_pkg::COUNT_RESET;
            cntHigh_q   <= timer_pkg::COUNT_RESET;
            perShadow_q <= timer_pkg::COUNT_RESET;
        end else if (wrLow) begin
            cntLow_q <= busReq.wrData;
            // buffered high byte moves in with the low byte
            if (ctrlA_q.widthSelect) begin
                cntHigh_q <= hiReg_q;
            end
        end else if (countTick) begin
            if (ctrlA_q.widthSelect) begin
                // only wrap and writes change it
                {cntHigh_q, cntLow_q} <= {cntHigh_q, cntLow_q} + 16'h0001;
            end else if (matchNow) begin
                // clear low byte and refresh the period shadow
                cntLow_q    <= timer_pkg::COUNT_RESET;
                perShadow_q <= hiReg_q;
            end else begin
                cntLow_q <= cntLow_q + 8'h01;
            end
        end
    end

    // high register is the period in 8-bit mode, the buffer in 16-bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hiReg_q <= timer_pkg::COUNT_RESET;
        end else if (wrHigh) begin
            hiReg_q <= busReq.wrData;
        end else if (rdLow && ctrlA_q.widthSelect) begin
            // coherent sample of the high byte
            hiReg_q <= cntHigh_q;
        end
    end

    // ==========================================================
    // postscaler, output and interrupt flag
    // divide by field plus one
    event_divider #(
        .W (timer_pkg::POST_W)
    ) u_post (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clear   (scalerClear),
        .inTick  (rollEvent),
        .limit   (ctrlA_q.postscaleField),
        .outTick (postTick)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_q <= 1'b0;
        end else if (postTick) begin
            out_q <= !out_q;
        end
    end

    // toggle sets the flag; a set beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqFlag_q <= timer_pkg::IRQ_RESET;
        end else if (postTick) begin
            irqFlag_q <= 1'b1;
        end else if (wrIrq) begin
            irqFlag_q <= busReq.wrData[timer_pkg::IRQ_FLAG_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqEnable_q <= timer_pkg::IRQ_RESET;
        end else if (wrIrq) begin
            irqEnable_q <= busReq.wrData[timer_pkg::IRQ_ENABLE_BIT];
        end
    end

    // output routed to the pin side
    assign timerOut    = out_q;
    assign irqRequest  = irqFlag_q && irqEnable_q;
    // wake only when counting on without the system rate
    assign wakeRequest = sleepActive && ctrlB_q.asyncEnable && ctrlA_q.moduleEnable && irqRequest;

    // ==========================================================
    // read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst || !busReq.rdStrobe) begin
            rdData_q <= timer_pkg::READ_IDLE;
        end else begin
            case (busReq.addr)
                timer_pkg::ADDR_COUNT_LOW:  rdData_q <= cntLow_q;
                timer_pkg::ADDR_COUNT_HIGH: rdData_q <= hiReg_q;
                // status bit five shows the output
                timer_pkg::ADDR_CTRL_A:     rdData_q <= {ctrlA_q.moduleEnable, 1'b0, out_q,
                                                         ctrlA_q.widthSelect, ctrlA_q.postscaleField};
                timer_pkg::ADDR_CTRL_B:     rdData_q <= ctrlB_q;
                timer_pkg::ADDR_IRQ_CTRL:   rdData_q <= {6'h00, irqEnable_q, irqFlag_q};
                default:                    rdData_q <= timer_pkg::READ_IDLE;
            endcase
        end
    end

    assign rdData = rdData_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_match_clears_low: assert property (
        countTick && !ctrlA_q.widthSelect && matchNow && !wrLow
        |=> cntLow_q == 8'h00 && perShadow_q == $past(hiReg_q))
        else $error("8-bit match did not clear and reload");

    a_wrap_to_zero: assert property (
        countTick && ctrlA_q.widthSelect && {cntHigh_q, cntLow_q} == 16'hffff && !wrLow
        |=> {cntHigh_q, cntLow_q} == 16'h0000)
        else $error("16-bit counter did not wrap to zero");

    a_high_latch: assert property (
        rdLow && ctrlA_q.widthSelect && !wrHigh |=> hiReg_q == $past(cntHigh_q))
        else $error("low read did not latch high byte");

    a_high_transfer: assert property (
        wrLow && ctrlA_q.widthSelect |=> cntHigh_q == $past(hiReg_q) && cntLow_q == $past(busReq.wrData))
        else $error("low write did not move buffered high byte");

    a_disabled_holds: assert property (
        !ctrlA_q.moduleEnable && !wrLow && !wrCtrlA ##1 !ctrlA_q.moduleEnable
        |-> $stable(cntLow_q) && $stable(cntHigh_q) && $stable(out_q))
        else $error("disabled timer changed state");

    a_sleep_halts: assert property (
        sleepActive && !ctrlB_q.asyncEnable |-> !countTick)
        else $error("synchronous timer counted in sleep");

    a_toggle_sets_flag: assert property (
        $changed(out_q) |-> irqFlag_q)
        else $error("output toggle without interrupt flag");

    a_status_bit: assert property (
        busReq.rdStrobe && busReq.addr == timer_pkg::ADDR_CTRL_A |=> rdData[5] == $past(out_q))
        else $error("status bit does not show output");

    a_clear_restarts: assert property (
        scalerClear |=> u_pres.count_q == 15'h0 && u_post.count_q == 4'h0)
        else $error("scalers not cleared by low or control write");

    a_wake_gate: assert property (
        wakeRequest |-> irqFlag_q && irqEnable_q && ctrlB_q.asyncEnable)
        else $error("wake without enabled asynchronous interrupt");

    c_match_8bit: cover property (rollEvent && !ctrlA_q.widthSelect);
    c_wrap_16bit: cover property (rollEvent && ctrlA_q.widthSelect);
    c_post_toggle: cover property (postTick && ctrlA_q.postscaleField != 4'h0);
    c_wake_seen: cover property (wakeRequest);

endmodule

// ==== verification/test_configurable_timer_8_16_bit.sv ====
/*
 * Self-checking bench for the 8/16-bit timer: register port tasks and
 * scenario sequences with expected values worked out from the register map.
 * Assumes timer_pkg and timer_core compiled before; the core holds its own assertions.
 */
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_configurable_timer_8_16_bit;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_sys;
    logic                srst;
    logic                sleepActive;
    logic [3:0]          rawIn;
    timer_pkg::bus_req_t busReq;
    logic [7:0]          rdData;
    logic                timerOut;
    logic                irqRequest;
    logic                wakeRequest;
    int                  error_cnt;
    int                  total_checks;
    int                  n;
    logic [7:0]          rv;
    logic                outExp;

    timer_core uut (
        .clk_sys     (clk_sys),
        .srst        (srst),
        .busReq      (busReq),
        .rdData      (rdData),
        .pinIn       (rawIn[timer_pkg::RAW_PIN]),
        .hfOscIn     (rawIn[timer_pkg::RAW_HFOSC]),
        .lfOscIn     (rawIn[timer_pkg::RAW_LFOSC]),
        .secOscIn    (rawIn[timer_pkg::RAW_SECOSC]),
        .sleepActive (sleepActive),
        .timerOut    (timerOut),
        .irqRequest  (irqRequest),
        .wakeRequest (wakeRequest)
    );

    // ==========================================================
    // clock, reset and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // about 900 cycles of tests; a generous margin stops a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    // ==========================================================
    // register port and stimulus tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{wrStrobe: 1'b1, rdStrobe: 1'b0, addr: a, wrData: d};
        @(posedge clk_sys);
        busReq <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{wrStrobe: 1'b0, rdStrobe: 1'b1, addr: a, wrData: 8'h00};
        @(posedge clk_sys);
        busReq <= '0;
        #1 d = rdData;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        rd(a, v);
        `CHK(nm, e, v)
    endtask

    // slow pulses: well under half the system clock, as the synchronisers need
    task automatic pulses(input int idx, input int cnt);
        repeat (cnt) begin
            @(posedge clk_sys);
            rawIn[idx] <= 1'b1;
            repeat (6) @(posedge clk_sys);
            rawIn[idx] <= 1'b0;
            repeat (6) @(posedge clk_sys);
        end
    endtask

    task automatic untilToggle(output int cnt);
        logic t0;
        t0 = timerOut;
        cnt = 0;
        do begin
            pulses(timer_pkg::RAW_PIN, 1);
            cnt++;
        end while (timerOut === t0 && cnt < 20);
    endtask

    function automatic int srcIdx(input int code);
        case (code)
            3: return timer_pkg::RAW_HFOSC;
            4: return timer_pkg::RAW_LFOSC;
            5: return timer_pkg::RAW_SECOSC;
            default: return timer_pkg::RAW_PIN;
        endcase
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        srst = 1'b1;
        sleepActive = 1'b0;
        rawIn = 4'h0;
        busReq = '0;
        error_cnt = 0;
        total_checks = 0;
        outExp = 1'b0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        rdChk(timer_pkg::ADDR_CTRL_A, 8'h00, "ctrl a reset");
        rdChk(timer_pkg::ADDR_CTRL_B, 8'h00, "ctrl b reset");
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h00, "low reset");
        rdChk(timer_pkg::ADDR_COUNT_HIGH, 8'h00, "high reset");
        wr(12'hfd8, 8'hff);
        rdChk(12'hfd8, 8'h00, "unmapped read");
        rdChk(timer_pkg::ADDR_CTRL_A, 8'h00, "unmapped write");
        $display("test reset values done");

        // 8-bit period 3, postscale 1:2; shadow starts at zero
        wr(timer_pkg::ADDR_COUNT_HIGH, 8'h03);
        wr(timer_pkg::ADDR_CTRL_B, 8'h10);
        wr(timer_pkg::ADDR_CTRL_A, 8'h81);
        untilToggle(n);
        `CHK("first toggle ticks", 5, n)
        outExp = ~outExp;
        rdChk(timer_pkg::ADDR_CTRL_A, {2'h2, outExp, 5'h01}, "output bit");
        rdChk(timer_pkg::ADDR_IRQ_CTRL, 8'h01, "irq flag set");
        untilToggle(n);
        `CHK("period toggle ticks", 8, n)
        outExp = ~outExp;
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h00, "low after match");
        wr(timer_pkg::ADDR_IRQ_CTRL, 8'h00);
        $display("test 8-bit period done");

        // every source code, 16-bit, asynchronous, no prescale
        wr(timer_pkg::ADDR_CTRL_A, 8'h90);
        wr(timer_pkg::ADDR_COUNT_HIGH, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(timer_pkg::ADDR_CTRL_B, {3'(c), 1'b1, 4'h0});
            repeat (8) @(posedge clk_sys);
            wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
            pulses(srcIdx(c), 3);
            rd(timer_pkg::ADDR_COUNT_LOW, rv);
            if (c == 2) begin
                `CHK("instr count", 1'b1, (rv >= 8'h08 && rv <= 8'h0c))
            end else begin
                `CHK("source count", ((c >= 6) ? 8'h00 : 8'h03), rv)
            end
        end
        $display("test clock sources done");

        // prescale 1:4, hidden count cleared by a low byte write
        wr(timer_pkg::ADDR_CTRL_B, 8'h12);
        wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
        pulses(timer_pkg::RAW_PIN, 3);
        wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
        pulses(timer_pkg::RAW_PIN, 3);
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h00, "prescale cleared");
        pulses(timer_pkg::RAW_PIN, 1);
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h01, "prescale 1:4");
        $display("test prescaler done");

        // synchronous mode halts in sleep
        wr(timer_pkg::ADDR_CTRL_B, 8'h00);
        wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
        sleepActive <= 1'b1;
        pulses(timer_pkg::RAW_PIN, 3);
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h00, "sync in sleep");
        sleepActive <= 1'b0;
        pulses(timer_pkg::RAW_PIN, 3);
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h03, "sync awake");

        // asynchronous wrap in sleep wakes the device
        wr(timer_pkg::ADDR_CTRL_B, 8'h10);
        wr(timer_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(timer_pkg::ADDR_COUNT_LOW, 8'hfe);
        wr(timer_pkg::ADDR_IRQ_CTRL, 8'h02);
        sleepActive <= 1'b1;
        pulses(timer_pkg::RAW_PIN, 2);
        outExp = ~outExp;
        `CHK("wrap toggle", outExp, timerOut)
        `CHK("irq request", 1'b1, irqRequest)
        `CHK("wake request", 1'b1, wakeRequest)
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h00, "low after wrap");
        rdChk(timer_pkg::ADDR_COUNT_HIGH, 8'h00, "high after wrap");
        sleepActive <= 1'b0;
        wr(timer_pkg::ADDR_IRQ_CTRL, 8'h01);
        // the enable lands at the edge that ends wr; look once it has settled
        #1;
        `CHK("irq masked", 1'b0, irqRequest)
        rdChk(timer_pkg::ADDR_IRQ_CTRL, 8'h01, "flag kept");
        wr(timer_pkg::ADDR_IRQ_CTRL, 8'h00);
        rdChk(timer_pkg::ADDR_IRQ_CTRL, 8'h00, "flag cleared");
        $display("test sleep and wake done");

        // disabled 16-bit: buffered high byte and held count
        wr(timer_pkg::ADDR_CTRL_A, 8'h10);
        wr(timer_pkg::ADDR_COUNT_HIGH, 8'h12);
        wr(timer_pkg::ADDR_COUNT_LOW, 8'h34);
        pulses(timer_pkg::RAW_PIN, 3);
        `CHK("disabled output", outExp, timerOut)
        wr(timer_pkg::ADDR_COUNT_HIGH, 8'h56);
        rdChk(timer_pkg::ADDR_COUNT_LOW, 8'h34, "held low");
        rdChk(timer_pkg::ADDR_COUNT_HIGH, 8'h12, "latched high");
        rdChk(timer_pkg::ADDR_CTRL_A, {2'h0, outExp, 5'h10}, "ctrl a readback");
        $display("test buffered access done");
        results();
    end
endmodule
